/* src/spp_packer.sv */
`timescale 1ns/10ps
`default_nettype none

module spp_packer #(
    parameter int unsigned MS_CYCLES = spp_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Packing configuration
    input wire logic [10:0] pkt_len,
    input wire logic [7:0] delim1,
    input wire logic [7:0] delim2,
    input wire logic [1:0] delim_mode,
    input wire logic [15:0] force_tx_ms,
    // Session configuration
    input wire logic [6:0] session_idle_close_minutes,
    input wire logic [15:0] inact_ms,
    input wire logic connect_any_char,
    input wire logic skip_stalled_host,
    input wire logic [2:0] max_conn,
    input wire logic [3:0] dest_enable,
    // Serial side
    input wire logic ser_valid,
    output logic ser_ready,
    input wire logic [7:0] ser_data,
    input wire logic ser_tx_strobe,
    // Network frame output
    output logic net_valid,
    input wire logic net_ready,
    output logic [7:0] net_data,
    output logic net_last,
    // Session status to and from the network stack
    input wire logic session_open,
    input wire logic tcp_activity,
    input wire logic ka_answer,
    output logic ka_probe,
    output logic session_close,
    output logic listening,
    // Per-destination hosts
    input wire logic [3:0] host_connected,
    input wire logic [3:0] host_ack,
    input wire logic [3:0] host_stalled,
    output logic [3:0] dial_req,
    // Status
    output logic [10:0] buf_count,
    output logic frame_busy,
    output logic group_wait
);

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    typedef struct packed {
        logic [spp_pkg::BUF_BYTES-1:0][7:0] mem;
        logic [10:0] cnt;
        logic [10:0] rd;
        logic drain;
        logic prev_d1;
        logic [1:0] after;
        logic [15:0] pre;
        logic tick;
        logic [15:0] rx_idle;
        logic [15:0] ser_idle;
        logic [15:0] min_ms;
        logic [6:0] tcp_min;
        spp_pkg::spp_ka_t ka;
        logic [15:0] ka_ms;
        logic ka_probe;
        logic close;
        logic listening;
        logic open_d;
        logic [3:0] pend;
        logic [3:0] dial;
    } spp_state_t;

    spp_state_t st;
    spp_state_t next_st;

    // zero byte marks a delimiter unused
    function automatic logic delim_on(input logic [7:0] d);
        delim_on = (d != spp_pkg::DELIM_NONE);
    endfunction : delim_on

    logic acc;
    logic d_on;
    logic match;
    logic strip;
    logic [10:0] inc_cnt;
    logic push_valid;
    logic push_ready;
    logic push_last;
    logic inact_live;
    logic tcp_close;
    logic inact_close;
    logic ka_close;
    logic skip_live;

    // Serial byte taken whenever no frame drains
    assign acc = ser_valid && !st.drain;
    assign ser_ready = !st.drain;
    assign inc_cnt = 11'(st.cnt + 11'h1);

    assign d_on = delim_on(delim1);
    // second byte must follow the first
    assign match = d_on && (delim_on(delim2) ? (st.prev_d1 && ser_data == delim2) : (ser_data == delim1));
    assign strip = match && (delim_mode == spp_pkg::MODE_STRIP);

    // next group waits on pending acceptance
    assign push_valid = st.drain && (st.pend == 4'h0);
    assign push_last = (11'(st.rd + 11'h1) == st.cnt);

    // inactivity live only with any-character connect
    assign inact_live = connect_any_char && (inact_ms != 16'h0000);
    assign skip_live = skip_stalled_host && (max_conn > 3'h1);

    assign tcp_close = session_open && (session_idle_close_minutes != 7'h00) &&
                       (st.tcp_min >= session_idle_close_minutes);
    // serial quiet for the set milliseconds
    assign inact_close = session_open && inact_live && (st.ser_idle >= inact_ms);
    assign ka_close = session_open && (st.ka == spp_pkg::KA_WAIT) && (st.ka_ms >= spp_pkg::KA_WAIT_MS);

    // Framing, timers and session in one next-state process
    always_comb
    begin
        next_st = st;
        next_st.ka_probe = 1'b0;
        next_st.close = 1'b0;

        // millisecond tick from the system clock
        next_st.tick = (st.pre == MS_LAST);
        next_st.pre = next_st.tick ? 16'h0000 : 16'(st.pre + 16'h1);

        // Force-transmit idle time since the last byte
        if (acc)
            next_st.rx_idle = 16'h0000;
        else if (st.tick && st.rx_idle != spp_pkg::MS_MAX)
            next_st.rx_idle = 16'(st.rx_idle + 16'h1);

        // Serial line activity covers both directions
        if (acc || ser_tx_strobe || !session_open)
            next_st.ser_idle = 16'h0000;
        else if (st.tick && st.ser_idle != spp_pkg::MS_MAX)
            next_st.ser_idle = 16'(st.ser_idle + 16'h1);

        // minute count for the alive check
        if (tcp_activity || !session_open)
        begin
            next_st.min_ms = 16'h0000;
            next_st.tcp_min = 7'h00;
        end
        else if (st.tick)
        begin
            if (16'(st.min_ms + 16'h1) == spp_pkg::MS_PER_MIN)
            begin
                next_st.min_ms = 16'h0000;
                if (st.tcp_min != spp_pkg::MIN_MAX)
                    next_st.tcp_min = 7'(st.tcp_min + 7'h1);
            end
            else
                next_st.min_ms = 16'(st.min_ms + 16'h1);
        end

        // keep-alive runs while inactivity is off
        if (!session_open || inact_live)
        begin
            next_st.ka = spp_pkg::KA_IDLE;
            next_st.ka_ms = 16'h0000;
        end
        else
        begin
            case (st.ka)
                spp_pkg::KA_IDLE:
                begin
                    if (st.tick)
                        next_st.ka_ms = 16'(st.ka_ms + 16'h1);
                    if (st.tick && 16'(st.ka_ms + 16'h1) >= spp_pkg::KA_PERIOD_MS)
                    begin
                        next_st.ka_probe = 1'b1;
                        next_st.ka = spp_pkg::KA_WAIT;
                        next_st.ka_ms = 16'h0000;
                    end
                end
                spp_pkg::KA_WAIT:
                begin
                    if (ka_answer)
                    begin
                        next_st.ka = spp_pkg::KA_IDLE;
                        next_st.ka_ms = 16'h0000;
                    end
                    else if (st.tick && st.ka_ms != spp_pkg::MS_MAX)
                        next_st.ka_ms = 16'(st.ka_ms + 16'h1);
                end
                default:
                    next_st.ka = spp_pkg::KA_IDLE;
            endcase
        end

        // zero inactivity never reaches this close
        if (tcp_close || inact_close || ka_close)
        begin
            next_st.close = 1'b1;
            next_st.ka = spp_pkg::KA_IDLE;
            next_st.ka_ms = 16'h0000;
            next_st.ser_idle = 16'h0000;
            next_st.tcp_min = 7'h00;
            next_st.min_ms = 16'h0000;
        end

        // Back to listening after a close until a new session
        next_st.open_d = session_open;
        if (st.close)
            next_st.listening = 1'b1;
        else if (session_open && !st.open_d)
            next_st.listening = 1'b0;

        // open each enabled destination not yet connected
        next_st.dial = dest_enable & ~host_connected;

        // hosts leave the pending set as they accept
        for (int i = 0; i < 4; i++)
        begin
            if (host_ack[i] || !host_connected[i] || (skip_live && host_stalled[i]))
                next_st.pend[i] = 1'b0;
        end

        // Drain the frame into the output buffer
        if (push_valid && push_ready)
        begin
            next_st.rd = 11'(st.rd + 11'h1);
            if (push_last)
            begin
                next_st.drain = 1'b0;
                next_st.cnt = 11'h000;
                next_st.rd = 11'h000;
                next_st.pend = host_connected;
            end
        end

        // store each accepted byte in the buffer, except a stripped delimiter
        if (acc)
        begin
            next_st.prev_d1 = (ser_data == delim1);
            next_st.cnt = inc_cnt;
            if (strip)
            begin
                next_st.cnt = st.cnt;
                if (delim_on(delim2) && st.cnt != 11'h000)
                    next_st.cnt = 11'(st.cnt - 11'h1);
            end
            else
                next_st.mem[st.cnt[9:0]] = ser_data;

            // count the trailing bytes after a delimiter
            if (st.after != 2'h0)
                next_st.after = 2'(st.after - 2'h1);
            else if (match && delim_mode == spp_pkg::MODE_PLUS1)
                next_st.after = 2'h1;
            else if (match && delim_mode == spp_pkg::MODE_PLUS2)
                next_st.after = 2'h2;

            if (!d_on ||
                (match && st.after == 2'h0 && (delim_mode == spp_pkg::MODE_NOTHING || strip)) ||
                (st.after == 2'h1) ||
                (pkt_len != 11'h000 && inc_cnt == pkt_len) ||
                (inc_cnt == spp_pkg::CNT_FULL))
            begin
                if (next_st.cnt != 11'h000)
                    next_st.drain = 1'b1;
                next_st.after = 2'h0;
                next_st.rd = 11'h000;
            end
        end
        else if (!st.drain && st.cnt != 11'h000 && force_tx_ms != 16'h0000 &&
                 st.rx_idle >= force_tx_ms)
        begin
            next_st.drain = 1'b1;
            next_st.after = 2'h0;
            next_st.rd = 11'h000;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Two-entry buffer so a network stall drops no byte
    spp_buf2 #(
        .W(9)
    ) u_out_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data({push_last, st.mem[st.rd[9:0]]}),
        .out_valid(net_valid),
        .out_ready(net_ready),
        .out_data({net_last, net_data})
    );

    // Status and pulses from flops
    assign ka_probe = st.ka_probe;
    assign session_close = st.close;
    assign listening = st.listening;
    assign dial_req = st.dial;
    assign buf_count = st.cnt;
    assign frame_busy = st.drain;
    assign group_wait = (st.pend != 4'h0);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_byte_in;
        acc;
    endsequence

    sequence s_trailing_last;
        s_byte_in ##0 (st.after == 2'h1);
    endsequence

    ms_tick_a: assert property (st.tick |=> !st.tick)
        else $error("millisecond tick lasted two cycles");
    nodelim_fwd_a: assert property (s_byte_in ##0 !d_on |=> st.drain && st.cnt == $past(inc_cnt))
        else $error("byte not forwarded without delimiter");
    full_pack_a: assert property (s_byte_in ##0 st.cnt == 11'h3ff && !strip |=> st.drain)
        else $error("full buffer not packed");
    pkt_len_a: assert property (s_byte_in ##0 pkt_len != 11'h000 && inc_cnt == pkt_len && !strip |=> st.drain)
        else $error("packet length not honoured");
    strip_one_a: assert property (s_byte_in ##0 strip && !delim_on(delim2) |=> st.cnt == $past(st.cnt))
        else $error("stripped delimiter stored");
    plus_send_a: assert property (s_trailing_last |=> st.drain)
        else $error("plus mode did not send");
    group_hold_a: assert property (push_valid && push_ready && push_last |=> st.pend == $past(host_connected))
        else $error("accepting hosts not recorded at frame end");
    alive_zero_a: assert property (session_idle_close_minutes == 7'h00 && !inact_close && !ka_close
        |=> !st.close)
        else $error("alive check closed while off");
    inact_off_a: assert property (inact_ms == 16'h0000 && !tcp_close && !ka_close |=> !st.close)
        else $error("inactivity close while off");
    probe_wait_a: assert property (st.ka_probe && !st.close |-> st.ka == spp_pkg::KA_WAIT)
        else $error("probe without waiting for answer");

endmodule : spp_packer

`default_nettype wire

/* src/spp_pkg.sv */
package spp_pkg;

    // Serial receive buffer size per port
    localparam int BUF_BYTES = 1024;
    localparam logic [10:0] CNT_FULL = 11'h400;

    // Clock and millisecond tick
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] MS_PER_MIN = 16'hea60;

    // Keep-alive probing, in milliseconds
    localparam logic [15:0] KA_PERIOD_MS = 16'h03e8;
    localparam logic [15:0] KA_WAIT_MS = 16'h03e8;

    // Saturation limits of the idle counters
    localparam logic [15:0] MS_MAX = 16'hffff;
    localparam logic [6:0] MIN_MAX = 7'h7f;

    // Delimiter character meaning unused
    localparam logic [7:0] DELIM_NONE = 8'h00;

    // Delimiter handling modes
    localparam logic [1:0] MODE_NOTHING = 2'h0;
    localparam logic [1:0] MODE_PLUS1 = 2'h1;
    localparam logic [1:0] MODE_PLUS2 = 2'h2;
    localparam logic [1:0] MODE_STRIP = 2'h3;

    // Keep-alive states
    typedef enum logic {KA_IDLE, KA_WAIT} spp_ka_t;

endpackage : spp_pkg

/* src/spp_buf2.sv */
`timescale 1ns/10ps
`default_nettype none

module spp_buf2 #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    typedef struct packed {
        logic [1:0][W-1:0] q;
        logic [1:0] n;
    } spp_buf_t;

    spp_buf_t st;
    spp_buf_t next_st;

    // Handshakes straight from the fill level
    assign out_valid = (st.n != 2'h0);
    assign in_ready = (st.n != 2'h2);
    assign out_data = st.q[0];

    // Pop shifts the head out, push lands behind it
    always_comb
    begin
        next_st = st;
        if (out_valid && out_ready)
        begin
            next_st.q[0] = st.q[1];
            next_st.n = 2'(next_st.n - 2'h1);
        end
        if (in_valid && in_ready)
        begin
            next_st.q[next_st.n[0]] = in_data;
            next_st.n = 2'(next_st.n + 2'h1);
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

endmodule : spp_buf2

`default_nettype wire

/* sim/spp_net_peer.sv */
`timescale 1ns/10ps
`default_nettype none

module spp_net_peer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Frame stream from the packer
    input wire logic net_valid,
    input wire logic net_last,
    output logic net_ready,
    // Remote host behaviour
    input wire logic mute,
    input wire logic [3:0] hosts,
    input wire logic ka_probe,
    output logic ka_answer,
    output logic [3:0] host_ack,
    output logic [3:0] host_connected
);
    logic [1:0] beat;

    // Stall one cycle in four so the output buffer backs up
    assign net_ready = beat != 2'h3;
    assign host_connected = hosts;

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            beat <= 2'h0;
            ka_answer <= 1'b0;
            host_ack <= 4'h0;
        end
        else
        begin
            beat <= beat + 2'h1;
            ka_answer <= ka_probe && !mute; // A muted host lets probes lapse
            host_ack <= {3'h0, net_valid && net_ready && net_last};
        end
    end
endmodule : spp_net_peer

`default_nettype wire

/* sim/spp_packer_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module spp_packer_tb;
    localparam int MSC = 4;
    // Stimulus
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [10:0] pkt_len = 11'h000;
    logic [7:0] delim1 = 8'h00;
    logic [7:0] delim2 = 8'h00;
    logic [1:0] delim_mode = 2'h0;
    logic [15:0] force_tx_ms = 16'h0000;
    logic [15:0] inact_ms = 16'h0000;
    logic [6:0] session_idle_close_minutes = 7'h00;
    logic connect_any_char = 1'b0;
    logic ser_valid = 1'b0;
    logic [7:0] ser_data = 8'h00;
    logic ser_tx_strobe = 1'b0;
    logic session_open = 1'b0;
    logic mute = 1'b0;
    logic skip_stalled_host = 1'b0;
    logic [2:0] max_conn = 3'h1;
    logic [3:0] dest_enable = 4'hf;
    logic [3:0] host_stalled = 4'h0;
    logic [3:0] hosts = 4'h1;
    // Responses
    logic ser_ready, net_valid, net_ready, net_last, ka_probe, ka_answer, session_close, frame_busy;
    logic [7:0] net_data;
    logic [3:0] host_ack, host_connected;
    logic [10:0] buf_count;
    logic listening, group_wait;
    logic [3:0] dial_req;
    // Model state
    int unsigned seed = 94697;
    logic [8:0] exp_q[$];
    logic [7:0] held[$];
    logic [7:0] prev = 8'h00;
    int plus_left = 0;
    int failures = 0;
    int n_compared = 0;
    int n_close = 0;
    int n_probe = 0;
    int base = 0;
    int base_p = 0;

    spp_packer #(.MS_CYCLES(MSC)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pkt_len(pkt_len), .delim1(delim1), .delim2(delim2),
        .delim_mode(delim_mode), .force_tx_ms(force_tx_ms),
        .session_idle_close_minutes(session_idle_close_minutes), .inact_ms(inact_ms),
        .connect_any_char(connect_any_char), .skip_stalled_host(skip_stalled_host), .max_conn(max_conn),
        .dest_enable(dest_enable), .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_data(ser_data),
        .ser_tx_strobe(ser_tx_strobe), .net_valid(net_valid), .net_ready(net_ready),
        .net_data(net_data), .net_last(net_last), .session_open(session_open), .tcp_activity(1'b0),
        .ka_answer(ka_answer), .ka_probe(ka_probe), .session_close(session_close), .listening(listening),
        .host_connected(host_connected), .host_ack(host_ack), .host_stalled(host_stalled), .dial_req(dial_req),
        .buf_count(buf_count), .frame_busy(frame_busy), .group_wait(group_wait)
    );

    spp_net_peer peer (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .net_valid(net_valid), .net_last(net_last),
        .net_ready(net_ready), .mute(mute), .hosts(hosts), .ka_probe(ka_probe), .ka_answer(ka_answer),
        .host_ack(host_ack), .host_connected(host_connected)
    );

    // Clock generation
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    // Bytes stay in 40..7f, clear of any delimiter
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {2'b01, seed[5:0]};
    endfunction : rnd

    task automatic pack_model();
        for (int i = 0; i < held.size(); i++)
            exp_q.push_back({i == held.size() - 1, held[i]});
        held.delete();
        plus_left = 0;
    endtask : pack_model

    // Reference packing of one accepted byte
    task automatic model(input logic [7:0] b);
        logic hit;
        logic fire;
        hit = delim1 != 8'h00 && (delim2 == 8'h00 ? b == delim1 : (prev == delim1 && b == delim2));
        prev = b;
        if (hit && delim_mode == spp_pkg::MODE_STRIP)
        begin
            if (delim2 != 8'h00 && held.size() > 0)
                void'(held.pop_back());
        end
        else
            held.push_back(b);
        fire = delim1 == 8'h00 || (pkt_len != 11'h000 && held.size() == pkt_len) || held.size() == 1024;
        if (plus_left > 0)
        begin
            plus_left--;
            fire |= plus_left == 0;
        end
        else if (hit && (delim_mode == spp_pkg::MODE_PLUS1 || delim_mode == spp_pkg::MODE_PLUS2))
            plus_left = delim_mode;
        else if (hit)
            fire = 1'b1;
        if (fire)
            pack_model();
    endtask : model

    // Hold the byte until it is taken at an edge
    task automatic send(input logic [7:0] b);
        int k;
        ser_valid <= 1'b1;
        ser_data <= b;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (ser_ready !== 1'b1 && k < 5000);
        if (ser_ready !== 1'b1)
            failures++;
        model(b);
    endtask : send

    // bytes back to back, far inside force transmit
    task automatic burst(input int n);
        repeat (n) send(rnd());
    endtask : burst

    task automatic drain();
        int k;
        ser_valid <= 1'b0;
        k = 0;
        @(posedge clk_sys);
        while ((exp_q.size() > 0 || frame_busy !== 1'b0) && k < 5000)
        begin
            @(posedge clk_sys);
            k++;
        end
        check(32'(exp_q.size()), 32'h0);
        check(32'(frame_busy), 32'h0);
    endtask : drain

    // Leftover bytes go out once the line stays quiet
    task automatic idle_flush();
        int n;
        ser_valid <= 1'b0;
        n = held.size();
        pack_model();
        force_tx_ms <= 16'h0003;
        repeat (2) @(posedge clk_sys);
        check(32'(buf_count), 32'(n));
        repeat (8 * MSC) @(posedge clk_sys);
        force_tx_ms <= 16'h0000;
        drain();
    endtask : idle_flush

    task automatic cfg(input logic [7:0] d1, input logic [7:0] d2, input logic [1:0] m, input logic [10:0] len);
        delim1 <= d1;
        delim2 <= d2;
        delim_mode <= m;
        pkt_len <= len;
        prev = 8'h00;
        @(posedge clk_sys);
    endtask : cfg

    task automatic report_and_stop();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Every byte handed on is matched against the model
    always @(posedge clk_sys)
    begin
        if (session_close === 1'b1)
            n_close++;
        if (ka_probe === 1'b1)
            n_probe++;
        if (net_valid === 1'b1 && net_ready === 1'b1)
            check(32'({net_last, net_data}), 32'(exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff));
    end

    // Hang guard, far beyond the expected run
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        failures++;
        report_and_stop();
    end

    initial
    begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        session_open <= 1'b1;
        @(posedge clk_sys);
        burst(5);
        drain();
        cfg(8'h00, 8'h0a, 2'h0, 11'h000);
        burst(3);
        drain();
        for (int m = 0; m < 4; m++)
        begin
            cfg(8'h0d, 8'h00, 2'(m), 11'h000);
            burst(4);
            send(8'h0d);
            burst(3);
            idle_flush();
        end
        // two-character sequence with a stray first
        cfg(8'h0d, 8'h0a, 2'h3, 11'h000);
        burst(2);
        send(8'h0d);
        burst(1);
        send(8'h0d);
        send(8'h0a);
        drain();
        cfg(8'h0d, 8'h00, 2'h0, 11'h007);
        burst(14);
        drain();
        cfg(8'h0d, 8'h00, 2'h0, 11'h000);
        burst(1030);
        idle_flush();
        // second host stalls; skipping needs two connections
        cfg(8'h00, 8'h00, 2'h0, 11'h000);
        check(32'(dial_req), 32'he);
        hosts <= 4'h3;
        host_stalled <= 4'h2;
        skip_stalled_host <= 1'b1;
        send(rnd());
        send(rnd());
        ser_valid <= 1'b0;
        repeat (40) @(posedge clk_sys);
        check(32'(group_wait), 32'h1);
        check(32'(exp_q.size()), 32'h1);
        max_conn <= 3'h2;
        drain();
        hosts <= 4'h1;
        host_stalled <= 4'h0;
        base = n_close;
        connect_any_char <= 1'b1;
        // force transmit stays off, below inactivity
        inact_ms <= 16'h0005;
        ser_tx_strobe <= 1'b1;
        @(posedge clk_sys);
        ser_tx_strobe <= 1'b0;
        repeat (40 * MSC) @(posedge clk_sys);
        check(32'(n_close != base), 32'h1);
        check(32'(listening), 32'h1);
        inact_ms <= 16'h0000;
        repeat (2) @(posedge clk_sys);
        base = n_close;
        repeat (200) @(posedge clk_sys);
        check(32'(n_close - base), 32'h0);
        inact_ms <= 16'h0005;
        connect_any_char <= 1'b0;
        repeat (2) @(posedge clk_sys);
        base = n_close;
        base_p = n_probe;
        repeat (9000) @(posedge clk_sys);
        check(32'(n_close - base), 32'h0);
        check(32'(n_probe != base_p), 32'h1);
        mute <= 1'b1;
        base = n_close;
        repeat (10000) @(posedge clk_sys);
        check(32'(n_close != base), 32'h1);
        report_and_stop();
    end
endmodule : spp_packer_tb

`default_nettype wire
